// ===== hw/dap_cfg.svh
// Offsets, field positions, reset values and masks of the parameter store
`ifndef DAP_CFG_SVH
`define DAP_CFG_SVH
`define DAP_OFS_PTR   12'h3E0
`define DAP_OFS_BG    12'h484
`define DAP_OFS_ALF   12'h488
`define DAP_OFS_PAT   12'h48C
`define DAP_OFS_TBC   12'h494
`define DAP_OFS_MODE  12'h4A0
`define DAP_OFS_STAT  12'h4A4
`define DAP_TRI_END   12'h100
`define DAP_MSK_BG    32'h0000FFFF
`define DAP_MSK_ALF   32'h000000FF
`define DAP_MSK_PAT   32'hFFFFFFFF
`define DAP_MSK_TBC   32'h0000FFFF
`define DAP_MSK_MODE  32'h00000007
`define DAP_RST_REG   32'h00000000
`define DAP_RST_PTR   5'h1F
`define DAP_WRAP32    5'h1F
`define DAP_WRAP24    5'h17
`define DAP_BIT_BT    15
`define DAP_MODE_C16  0
`define DAP_MODE_P24  1
`define DAP_MODE_GOU  2
`define DAP_TRI_YS    6'h00
`define DAP_TRI_XS    6'h01
`define DAP_TRI_LONG_EDGE_X_SLOPE  6'h02
`define DAP_TRI_XUS   6'h03
`define DAP_TRI_UPPER_EDGE_X_SLOPE 6'h04
`define DAP_TRI_XLS   6'h05
`define DAP_TRI_LOWER_EDGE_X_SLOPE 6'h06
`define DAP_TRI_USN   6'h07
`define DAP_TRI_LSN   6'h08
`define DAP_TRI_RS    6'h10
`define DAP_TRI_ZS    6'h20
`define DAP_TRI_DEPTH_EDGE_GRADIENT  6'h23
`define DAP_TRI_SS    6'h30
`define DAP_CNT_LSB   16
`define DAP_CNT_MSB   27
`define DAP_Y_STEP    32'h00010000
`endif

// ===== hw/dap_pkg.sv
// Types shared by the drawing parameter store
package dap_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dap_wb_req_t;

  typedef struct packed {
    logic        wr;
    logic [5:0]  idx;
    logic [31:0] dat;
  } dap_tri_load_t;

  typedef struct packed {
    logic        valid;
    logic        upper;
    logic [31:0] y;
    logic [31:0] x_long;
    logic [31:0] x_other;
  } dap_span_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] color;
  } dap_pix_t;

  // Red, green, blue, alpha, depth, s, t, q
  typedef logic [7:0][31:0] dap_attr_vec_t;

  typedef enum logic [1:0] {
    DAP_IDLE,
    DAP_UPPER,
    DAP_LOWER
  } dap_walk_t;
endpackage : dap_pkg

// ===== hw/dap_regs.sv
// Drawing attribute registers, triangle parameter store and span walker
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "dap_cfg.svh"
module dap_regs (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire dap_pkg::dap_wb_req_t   wb_req_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  // Command processor
  input  wire dap_pkg::dap_tri_load_t tri_load_i,
  input  wire logic                   tri_start_i,
  input  wire logic                   span_step_i,
  input  wire logic                   pix_step_i,
  // Pixel events
  input  wire logic [15:0]            fg_color_i,
  input  wire logic                   bl_pixel_i,
  input  wire logic                   bm_pixel_i,
  input  wire logic                   bm_bit_i,
  // Results
  output dap_pkg::dap_pix_t           pix_o,
  output dap_pkg::dap_span_t          span_o,
  output dap_pkg::dap_attr_vec_t      attr_o,
  output logic [7:0]                  blend_coef_o,
  output logic [15:0]                 border_color_o,
  output logic                        stencil_o
);
  import dap_pkg::*;

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  logic [31:0] background_color;
  logic [31:0] blend_coefficient;
  logic [31:0] dashed_line_pattern;
  logic [31:0] texture_border_color;
  logic [31:0] draw_mode_reg_one;
  logic [4:0]  pattern_bit_index;
  logic        ack_q;
  dap_walk_t   state;
  dap_span_t   span_q;

  wire         req      = wb_req_i.cyc & wb_req_i.stb;
  wire         commit   = req & ack_q & wb_req_i.we;
  wire [11:0]  wadr     = {wb_req_i.adr[11:2], 2'b00};
  wire [31:0]  bmask    = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                           {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire         hit_ptr  = wadr == `DAP_OFS_PTR;
  wire         hit_bg   = wadr == `DAP_OFS_BG;
  wire         hit_alf  = wadr == `DAP_OFS_ALF;
  wire         hit_pat  = wadr == `DAP_OFS_PAT;
  wire         hit_tbc  = wadr == `DAP_OFS_TBC;
  wire         hit_mode = wadr == `DAP_OFS_MODE;
  wire         hit_stat = wadr == `DAP_OFS_STAT;
  wire         ptr_wr   = commit & hit_ptr;
  wire         c16      = draw_mode_reg_one[`DAP_MODE_C16];
  wire         p24      = draw_mode_reg_one[`DAP_MODE_P24];
  wire         gouraud  = draw_mode_reg_one[`DAP_MODE_GOU];

  // Triangle window and holes both read zero; no path reaches tri_mem
  wire [31:0] rdata =
    hit_ptr  ? {27'h0000000, pattern_bit_index} :
    hit_bg   ? background_color :
    hit_alf  ? blend_coefficient :
    hit_pat  ? dashed_line_pattern :
    hit_tbc  ? texture_border_color :
    hit_mode ? draw_mode_reg_one :
    hit_stat ? {30'h00000000, span_q.upper, span_q.valid} :
    32'h00000000;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [31:0] bm,
                                        input logic [31:0] msk);
    merge = ((old & ~bm) | (dat & bm)) & msk;
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        wb_dat_o <= rdata;
      end
    end
  end
  assign wb_ack_o = ack_q;

  // ---------------------------------------------
  // Attribute registers
  // ---------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      background_color     <= `DAP_RST_REG;
      blend_coefficient    <= `DAP_RST_REG;
      dashed_line_pattern  <= `DAP_RST_REG;
      texture_border_color <= `DAP_RST_REG;
      draw_mode_reg_one    <= `DAP_RST_REG;
    end else if (commit) begin
      // Masks keep unused bits at zero
      if (hit_bg) begin
        background_color <= merge(background_color,
          wb_req_i.dat, bmask, `DAP_MSK_BG);
      end
      if (hit_alf) begin
        blend_coefficient <= merge(blend_coefficient,
          wb_req_i.dat, bmask, `DAP_MSK_ALF);
      end
      if (hit_pat) begin
        dashed_line_pattern <= merge(dashed_line_pattern,
          wb_req_i.dat, bmask, `DAP_MSK_PAT);
      end
      if (hit_tbc) begin
        texture_border_color <= merge(texture_border_color,
          wb_req_i.dat, bmask, `DAP_MSK_TBC);
      end
      if (hit_mode) begin
        draw_mode_reg_one <= merge(draw_mode_reg_one,
          wb_req_i.dat, bmask, `DAP_MSK_MODE);
      end
    end
  end

  // ---------------------------------------------
  // Pattern pointer and pixel colour
  // ---------------------------------------------
  wire [4:0]  wrap_val = p24 ? `DAP_WRAP24 : `DAP_WRAP32;
  // Pointer write merges byte lanes like the other registers
  wire [31:0] ptr_merge = merge({27'h0000000, pattern_bit_index},
                                wb_req_i.dat, bmask, 32'h0000001F);
  wire [4:0]  next_ptr =
    ptr_wr ? ptr_merge[4:0] :
    !bl_pixel_i ? pattern_bit_index :
    (pattern_bit_index == 5'h00) ? wrap_val :
    pattern_bit_index - 5'h01;
  wire        pat_bit  = dashed_line_pattern[pattern_bit_index];
  // Dashed line has priority if both pixel kinds arrive together
  wire        fg_sel   = bl_pixel_i ? pat_bit : bm_bit_i;
  wire        bt       = background_color[`DAP_BIT_BT];
  wire [15:0] bg_col   = c16 ? {1'b0, background_color[14:0]}
                             : {8'h00, background_color[7:0]};
  wire [15:0] fg_col   = c16 ? fg_color_i
                             : {8'h00, fg_color_i[7:0]};
  wire        pix_any  = bl_pixel_i | bm_pixel_i;
  wire        next_wr  = pix_any & (fg_sel | ~bt);
  wire [15:0] next_col = fg_sel ? fg_col : bg_col;
  wire [15:0] next_brd = c16 ? texture_border_color[15:0]
                             : {8'h00, texture_border_color[7:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_bit_index <= `DAP_RST_PTR;
      pix_o             <= '0;
      blend_coef_o      <= 8'h00;
      border_color_o    <= 16'h0000;
      stencil_o         <= 1'b0;
    end else begin
      pattern_bit_index <= next_ptr;
      pix_o             <= '{valid: pix_any, wr: next_wr,
                             color: next_col};
      blend_coef_o      <= blend_coefficient[7:0];
      border_color_o    <= next_brd;
      stencil_o         <= c16 & texture_border_color[15];
    end
  end

  // ---------------------------------------------
  // Triangle parameter store
  // ---------------------------------------------
  // Not reset: a drawing command loads a full set before each start
  logic [31:0] tri_mem [0:63];

  always_ff @(posedge clk_i) begin
    if (tri_load_i.wr) begin
      tri_mem[tri_load_i.idx] <= tri_load_i.dat;
    end
  end

  wire [11:0] upper_span_count = tri_mem[`DAP_TRI_USN][`DAP_CNT_MSB:`DAP_CNT_LSB];
  wire [11:0] lower_span_count = tri_mem[`DAP_TRI_LSN][`DAP_CNT_MSB:`DAP_CNT_LSB];

  // ---------------------------------------------
  // Span walker
  // ---------------------------------------------
  dap_walk_t   next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [31:0] next_y;
  logic [31:0] next_xl;
  logic [31:0] next_xo;
  logic        ld_start;
  logic        adv;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_y     = span_q.y;
    next_xl    = span_q.x_long;
    next_xo    = span_q.x_other;
    ld_start   = 1'b0;
    adv        = 1'b0;
    case (state)
      DAP_IDLE: begin
        if (tri_start_i) begin
          ld_start = 1'b1;
          next_y   = tri_mem[`DAP_TRI_YS];
          next_xl  = tri_mem[`DAP_TRI_XS];
          if (upper_span_count != 12'h000) begin
            next_state = DAP_UPPER;
            next_cnt   = upper_span_count;
            next_xo    = tri_mem[`DAP_TRI_XUS];
          end else if (lower_span_count != 12'h000) begin
            next_state = DAP_LOWER;
            next_cnt   = lower_span_count;
            next_xo    = tri_mem[`DAP_TRI_XLS];
          end
        end
      end
      DAP_UPPER, DAP_LOWER: begin
        if (span_step_i) begin
          adv      = 1'b1;
          next_cnt = cnt - 12'h001;
          // Signed 4.12.16 adds; sign extension rides along
          next_y   = span_q.y + `DAP_Y_STEP;
          next_xl  = span_q.x_long + tri_mem[`DAP_TRI_LONG_EDGE_X_SLOPE];
          next_xo  = span_q.x_other + ((state == DAP_UPPER)
                     ? tri_mem[`DAP_TRI_UPPER_EDGE_X_SLOPE]
                     : tri_mem[`DAP_TRI_LOWER_EDGE_X_SLOPE]);
          if (cnt == 12'h001) begin
            if (state == DAP_UPPER && lower_span_count != 12'h000) begin
              next_state = DAP_LOWER;
              next_cnt   = lower_span_count;
              next_xo    = tri_mem[`DAP_TRI_XLS];
            end else begin
              next_state = DAP_IDLE;
            end
          end
        end
      end
      default: next_state = DAP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= DAP_IDLE;
      cnt    <= 12'h000;
      span_q <= '0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      span_q <= '{valid: next_state != DAP_IDLE,
                  upper: next_state == DAP_UPPER,
                  y: next_y, x_long: next_xl, x_other: next_xo};
    end
  end
  assign span_o = span_q;

  // ---------------------------------------------
  // Attribute interpolation
  // ---------------------------------------------
  dap_attr_vec_t edge_acc;
  dap_attr_vec_t pix_acc;
  wire           reload = ld_start | adv;

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_attr
      localparam logic [5:0] SI = (k < 4) ? 6'(`DAP_TRI_RS + 3 * k) :
                                  (k == 4) ? `DAP_TRI_ZS :
                                  6'(`DAP_TRI_SS + 3 * (k - 5));
      localparam logic [5:0] DX = SI + 6'h01;
      localparam logic [5:0] DY = (k == 4) ? `DAP_TRI_DEPTH_EDGE_GRADIENT
                                           : SI + 6'h02;
      // Colour terms are dead unless Gouraud shading is on
      wire        en   = (k > 3) | gouraud;
      wire [31:0] st_v = en ? tri_mem[SI] : 32'h00000000;
      wire [31:0] dx_v = en ? tri_mem[DX] : 32'h00000000;
      wire [31:0] dy_v = en ? tri_mem[DY] : 32'h00000000;
      wire [31:0] next_edge = ld_start ? st_v :
                              adv ? edge_acc[k] + dy_v :
                              edge_acc[k];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          edge_acc[k] <= 32'h00000000;
          pix_acc[k]  <= 32'h00000000;
        end else begin
          edge_acc[k] <= next_edge;
          if (reload) begin
            pix_acc[k] <= next_edge;
          end else if (pix_step_i) begin
            pix_acc[k] <= pix_acc[k] + dx_v;
          end
        end
      end
    end
  endgenerate
  assign attr_o = pix_acc;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle");
  a_tri_hidden: assert property (
    req && !ack_q && wadr < `DAP_TRI_END |=> wb_dat_o == 32'h00000000)
    else $error("triangle window readable from bus");
  a_ptr_step: assert property (
    bl_pixel_i && !ptr_wr && pattern_bit_index != 5'h00
    |=> pattern_bit_index == $past(pattern_bit_index) - 5'h01)
    else $error("pattern pointer did not decrement");
  a_ptr_wrap: assert property (
    bl_pixel_i && !ptr_wr && pattern_bit_index == 5'h00
    |=> pattern_bit_index == ($past(p24) ? 5'h17 : 5'h1F))
    else $error("pattern pointer wrap value wrong");
  a_ptr_hold: assert property (
    !bl_pixel_i && !ptr_wr |=> $stable(pattern_bit_index))
    else $error("pattern pointer moved without a pixel");
  a_transp_skip: assert property (
    pix_any && !fg_sel && bt |=> pix_o.valid && !pix_o.wr)
    else $error("transparent background was written");
  a_dash_fg: assert property (
    bl_pixel_i && pat_bit |=> pix_o.wr && pix_o.color == $past(fg_col))
    else $error("dashed foreground pixel wrong");
  a_no_upper: assert property (
    state == DAP_IDLE && tri_start_i && upper_span_count == 12'h000
    |=> !span_o.upper)
    else $error("upper part drawn with zero spans");
  a_no_spans: assert property (
    state == DAP_IDLE && tri_start_i && upper_span_count == 12'h000
    && lower_span_count == 12'h000 |=> !span_o.valid ##1 !span_o.valid)
    else $error("triangle drawn with zero spans");
  a_flat_colour: assert property (
    ld_start && !gouraud |=> attr_o[0] == 32'h00000000)
    else $error("colour loaded outside Gouraud mode");
  a_border_narrow: assert property (
    !c16 |=> border_color_o[15:8] == 8'h00 && !stencil_o)
    else $error("narrow border colour leaked upper bits");
  a_blend_follow: assert property (
    1'b1 |=> blend_coef_o == $past(blend_coefficient[7:0]))
    else $error("blend coefficient output lagging");
endmodule : dap_regs

// ===== test/dap_cmd_model.sv
// Command processor model: triangle loads and pixel or span events
`timescale 1ns/1ps
module dap_cmd_model (
  // Clock
  input  wire logic                  clk_i,
  // Towards the store
  output dap_pkg::dap_tri_load_t     tri_load_o,
  output logic                       tri_start_o,
  output logic                       span_step_o,
  output logic                       pix_step_o,
  output logic [15:0]                fg_color_o,
  output logic                       bl_pixel_o,
  output logic                       bm_pixel_o,
  output logic                       bm_bit_o
);
  import dap_pkg::*;
  initial begin
    tri_load_o = '0;
    {bl_pixel_o, bm_pixel_o, bm_bit_o} = 3'h0;
    {tri_start_o, span_step_o, pix_step_o} = 3'h0;
    fg_color_o = 16'h5A3C;
  end
  // Only this path writes triangle words, never the bus
  task automatic ld(input logic [5:0] i, input logic [31:0] d);
    @(posedge clk_i);
    tri_load_o <= '{wr: 1'b1, idx: i, dat: d};
    @(posedge clk_i);
    // Released data must not look like a held word
    tri_load_o <= '{wr: 1'b0, idx: ~i, dat: ~d};
  endtask : ld
  // Foreground colour follows the host's register writes
  task automatic fg(input logic [15:0] c);
    @(posedge clk_i);
    fg_color_o <= c;
  endtask : fg
  // One-cycle pulses: bl, bm, bit, start, span, pix
  task automatic ev(input logic [5:0] v);
    @(posedge clk_i);
    {bl_pixel_o, bm_pixel_o, bm_bit_o,
     tri_start_o, span_step_o, pix_step_o} <= v;
    @(posedge clk_i);
    {bl_pixel_o, bm_pixel_o, bm_bit_o,
     tri_start_o, span_step_o, pix_step_o} <= 6'h00;
  endtask : ev
endmodule : dap_cmd_model

// ===== test/dap_regs_tb_top.sv
// Self-checking bench for the drawing parameter store
`timescale 1ns/1ps
`include "dap_cfg.svh"
module dap_regs_tb_top;
  import dap_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  dap_wb_req_t   wb_req = '0;
  logic          wb_ack;
  logic [31:0]   wb_dat;
  dap_tri_load_t tri_load;
  logic          tri_start, span_step, pix_step;
  logic [15:0]   fg_color;
  logic          bl_pixel, bm_pixel, bm_bit;
  dap_pix_t      pix;
  dap_span_t     span;
  dap_attr_vec_t attr;
  logic [7:0]    blend;
  logic [15:0]   border;
  logic          stencil;
  logic [31:0]   rd;
  logic [3:0]    be = 4'hF;
  int            err_count = 0;
  int            num_checks = 0;

  always #4 clk_i = ~clk_i;

  dap_cmd_model pm (.clk_i(clk_i), .tri_load_o(tri_load),
    .tri_start_o(tri_start), .span_step_o(span_step),
    .pix_step_o(pix_step), .fg_color_o(fg_color),
    .bl_pixel_o(bl_pixel), .bm_pixel_o(bm_pixel), .bm_bit_o(bm_bit));

  dap_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
    .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .tri_load_i(tri_load),
    .tri_start_i(tri_start), .span_step_i(span_step),
    .pix_step_i(pix_step), .fg_color_i(fg_color),
    .bl_pixel_i(bl_pixel), .bm_pixel_i(bm_pixel), .bm_bit_i(bm_bit),
    .pix_o(pix), .span_o(span), .attr_o(attr), .blend_coef_o(blend),
    .border_color_o(border), .stencil_o(stencil));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; waits for ack without assuming latency
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: be, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_req <= '0;
  endtask : wb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // Pixel event, then result one cycle later
  task automatic pchk(input logic [5:0] v, input logic w,
                      input logic [15:0] c);
    pm.ev(v);
    #1;
    chk({pix.valid, pix.wr, 14'h0, pix.color}, {1'b1, w, 14'h0, c});
  endtask : pchk

  logic [11:0] ofs [4] = '{`DAP_OFS_BG, `DAP_OFS_ALF, `DAP_OFS_PAT,
                           `DAP_OFS_TBC};
  logic [31:0] msk [4] = '{32'h0000FFFF, 32'h000000FF, 32'hFFFFFFFF,
                           32'h0000FFFF};

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // ------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------
    rchk(`DAP_OFS_PTR, 32'h0000001F);
    for (int i = 0; i < 4; i++) begin
      rchk(ofs[i], 32'h0);
      wb(1'b1, ofs[i], 32'hFFFFFFFF);
      rchk(ofs[i], msk[i]);
    end
    wb(1'b1, `DAP_OFS_PTR, 32'hFFFFFFFF);
    rchk(`DAP_OFS_PTR, 32'h0000001F);
    chk({stencil, border, blend}, {1'b0, 16'h00FF, 8'hFF});
    be = 4'h2;
    wb(1'b1, `DAP_OFS_BG, 32'h00001200);
    be = 4'hF;
    rchk(`DAP_OFS_BG, 32'h000012FF);
    wb(1'b1, `DAP_OFS_MODE, 32'h1);
    rchk(`DAP_OFS_MODE, 32'h1);
    chk({stencil, border, blend}, {1'b1, 16'hFFFF, 8'hFF});
    rchk(12'h300, 32'h0);
    $display("test registers done");
    // ------------------------------------------------------------
    // Dashed line and bitmap pixels
    // ------------------------------------------------------------
    wb(1'b1, `DAP_OFS_MODE, 32'h1);
    wb(1'b1, `DAP_OFS_BG, 32'h00001234);
    wb(1'b1, `DAP_OFS_PAT, 32'hA0000001);
    pchk(6'h20, 1'b1, 16'h5A3C);
    pchk(6'h20, 1'b1, 16'h1234);
    pchk(6'h20, 1'b1, 16'h5A3C);
    rchk(`DAP_OFS_PTR, 32'h1C);
    wb(1'b1, `DAP_OFS_PTR, 32'h0);
    pchk(6'h20, 1'b1, 16'h5A3C);
    rchk(`DAP_OFS_PTR, 32'h1F);
    wb(1'b1, `DAP_OFS_MODE, 32'h3);
    wb(1'b1, `DAP_OFS_PTR, 32'h0);
    pchk(6'h20, 1'b1, 16'h5A3C);
    rchk(`DAP_OFS_PTR, 32'h17);
    pchk(6'h10, 1'b1, 16'h1234);
    pchk(6'h18, 1'b1, 16'h5A3C);
    wb(1'b1, `DAP_OFS_BG, 32'h00009234);
    pm.ev(6'h20);
    #1;
    chk({pix.valid, pix.wr}, 2'b10);
    wb(1'b1, `DAP_OFS_MODE, 32'h0);
    wb(1'b1, `DAP_OFS_BG, 32'h00007F12);
    pchk(6'h10, 1'b1, 16'h0012);
    pm.fg(16'hC3A5);
    pchk(6'h18, 1'b1, 16'h00A5);
    $display("test pixels done");
    // ------------------------------------------------------------
    // Triangle walk
    // ------------------------------------------------------------
    wb(1'b1, `DAP_OFS_MODE, 32'h5);
    pm.ld(6'h00, 32'h00020000);
    pm.ld(6'h01, 32'h00050000);
    pm.ld(6'h02, 32'h00008000);
    pm.ld(6'h03, 32'h00060000);
    pm.ld(6'h04, 32'hFFFF0000);
    pm.ld(6'h05, 32'h00040000);
    pm.ld(6'h06, 32'h00010000);
    pm.ld(6'h07, 32'h00010000);
    pm.ld(6'h08, 32'h00010000);
    pm.ld(6'h10, 32'h00000100);
    pm.ld(6'h11, 32'h00000010);
    pm.ld(6'h12, 32'h00001000);
    pm.ld(6'h20, 32'h00008000);
    pm.ld(6'h30, 32'h00000200);
    pm.ld(6'h31, 32'h00000020);
    pm.ld(6'h32, 32'h00002000);
    wb(1'b1, 12'h000, 32'h7AB00000);
    rchk(12'h000, 32'h0);
    pm.ev(6'h04);
    #1;
    chk({30'h0, span.valid, span.upper}, 32'h3);
    chk(span.y, 32'h00020000);
    chk(span.x_long, 32'h00050000);
    chk(span.x_other, 32'h00060000);
    chk(attr[0], 32'h00000100);
    chk(attr[4], 32'h00008000);
    chk(attr[5], 32'h00000200);
    pm.ev(6'h01);
    #1;
    chk(attr[0], 32'h00000110);
    chk(attr[5], 32'h00000220);
    pm.ev(6'h02);
    #1;
    chk({30'h0, span.valid, span.upper}, 32'h2);
    chk(span.y, 32'h00030000);
    chk(span.x_long, 32'h00058000);
    chk(span.x_other, 32'h00040000);
    chk(attr[0], 32'h00001100);
    chk(attr[5], 32'h00002200);
    pm.ev(6'h02);
    #1;
    chk({31'h0, span.valid}, 32'h0);
    wb(1'b1, `DAP_OFS_MODE, 32'h1);
    pm.ld(6'h07, 32'h0);
    pm.ev(6'h04);
    #1;
    chk({30'h0, span.valid, span.upper}, 32'h2);
    chk(attr[0], 32'h0);
    chk(attr[5], 32'h00000200);
    pm.ev(6'h02);
    #1;
    chk({31'h0, span.valid}, 32'h0);
    pm.ld(6'h08, 32'h0);
    pm.ev(6'h04);
    #1;
    chk({31'h0, span.valid}, 32'h0);
    $display("test triangle done");
    complete_run();
  end
endmodule : dap_regs_tb_top
